/* tb/dvm_core_properties.sv */
// Purpose: port timing relations of the voltmeter core
// Assumes: clock enable held high
// Notes: helper counters measure pulse widths and start edge age
`timescale 1ns/1ns
module dvm_core_properties
    import dvm_pkg::*;
#(
    parameter logic [dvm_pkg::CYCLE_W-1:0] CYCLE_CLOCKS = dvm_pkg::CYCLE_CLOCKS_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic comparator_in,
    input wire logic polarity_in,
    input wire logic start_conversion,
    input wire logic reference_switch,
    input wire logic clock_out,
    input wire logic [dvm_pkg::SEG_W-1:0] segments,
    input wire logic [dvm_pkg::DIGITS-1:0] digit_drive,
    input wire logic overrange,
    input wire logic sign,
    input wire logic conversion_complete
);
    typedef struct packed {
        logic [6:0] hi_len;
        logic [8:0] edge_age;
        logic [7:0] lit_len;
        logic [3:0] last_drive;
        logic start_prev;
    } watch_s;
    watch_s w;
    watch_s next_w;
    always_comb begin
        next_w = w;
        next_w.start_prev = start_conversion;
        next_w.hi_len = conversion_complete ? w.hi_len + 7'h01 : 7'h00;
        next_w.lit_len = (digit_drive != DRIVE_NONE) ? w.lit_len + 8'h01 : 8'h00;
        if (digit_drive != DRIVE_NONE) begin
            next_w.last_drive = digit_drive;
        end
        if (start_conversion && !w.start_prev) begin
            next_w.edge_age = 9'h000;
        end else if (w.edge_age != 9'h1FF) begin
            next_w.edge_age = w.edge_age + 9'h001;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w <= '{7'h00, 9'h1FF, 8'h00, 4'h0, 1'b0};
        end else begin
            w <= next_w;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence blank_gap;
        (digit_drive == DRIVE_NONE) [*8];
    endsequence
    a_mod_delay: assert property ($past(reset_n, 3) |->
        reference_switch == $past(comparator_in, 3)) else $error("modulator lag wrong");
    a_clock_half: assert property ($past(reset_n) |->
        clock_out != $past(clock_out)) else $error("clock output not toggling");
    a_done_width: assert property ($fell(conversion_complete) |->
        w.hi_len == 7'h40 || w.edge_age < 9'h008) else $error("complete width wrong");
    a_done_cap: assert property (conversion_complete |-> w.hi_len < 7'h40)
        else $error("complete held too long");
    a_start_drop: assert property ($rose(start_conversion) |->
        ##[1:8] !conversion_complete) else $error("start did not drop complete");
    a_start_min: assert property ($rose(conversion_complete) |->
        w.edge_age >= 9'h0FF) else $error("complete too soon after start");
    a_blank_gap: assert property ($fell(digit_drive != DRIVE_NONE) |->
        blank_gap ##1 (digit_drive != DRIVE_NONE)) else $error("blanking gap wrong");
    a_lit_span: assert property ($fell(digit_drive != DRIVE_NONE) |->
        w.lit_len == 8'hF8) else $error("digit lit time wrong");
    a_digit_order: assert property ($rose(digit_drive != DRIVE_NONE) &&
        w.last_drive != DRIVE_NONE |-> digit_drive == {w.last_drive[2:0], w.last_drive[3]})
        else $error("digit order wrong");
    a_over_msd: assert property (overrange && digit_drive[3] && $past(overrange, 3) &&
        $past(sign, 3) == sign |-> segments == (sign ? SEG_PLUS : SEG_MINUS))
        else $error("overrange sign digit wrong");
    a_result_move: assert property ($changed(overrange) || $changed(sign) |->
        $rose(conversion_complete)) else $error("result moved without transfer");
endmodule

/* tb/loop_partner.sv */
// Purpose: comparator stand-in giving a fixed duty in a four-clock frame
// Assumes: duty 0 to 4 quarters
// Notes: moves on the falling edge, like the other bench inputs
`timescale 1ns/1ns
module loop_partner (
    input wire logic clk,
    input wire logic [2:0] duty,
    output logic comparator_in
);
    logic [1:0] phase = 2'h0;
    initial comparator_in = 1'b0;
    always @(negedge clk) begin
        phase <= phase + 2'h1;
        comparator_in <= ({1'b0, phase} < duty);
    end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the voltmeter core
// Assumes: shortened conversion cycle, clock enable held high
// Notes: free-run rows first, then start pulses by hand
`timescale 1ns/1ns
module tb_top;
    import dvm_pkg::*;
    localparam logic [CYCLE_W-1:0] CYC = 16'h1000;
    typedef struct packed {
        logic [2:0] duty;
        logic pol;
        logic over;
        logic [SEG_W-1:0] s3, s2, s1, s0;
    } row_s;
    logic clk, reset_n, polarity_in, start_conversion, comparator_in;
    logic reference_switch, clock_out, overrange, sign, conversion_complete;
    logic [2:0] duty;
    logic [SEG_W-1:0] segments;
    logic [DIGITS-1:0] digit_drive;
    int n_mismatch = 0;
    int cmp_count = 0;
    row_s rows [6];
    dvm_core #(.CYCLE_CLOCKS(CYC)) uut (.clk(clk), .reset_n(reset_n), .ce(1'b1),
        .comparator_in(comparator_in), .polarity_in(polarity_in),
        .start_conversion(start_conversion), .reference_switch(reference_switch),
        .clock_out(clock_out), .segments(segments), .digit_drive(digit_drive),
        .overrange(overrange), .sign(sign), .conversion_complete(conversion_complete));
    loop_partner far_side (.clk(clk), .duty(duty), .comparator_in(comparator_in));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_rise(output int n);
        logic prev;
        prev = conversion_complete;
        n = 0;
        while (!(prev === 1'b0 && conversion_complete === 1'b1)) begin
            prev = conversion_complete;
            @(negedge clk);
            n++;
            if (n > 9000) begin
                n_mismatch++;
                wrap_up();
            end
        end
    endtask
    task automatic check_digit(input int idx, input logic [SEG_W-1:0] exp);
        int n;
        n = 0;
        // step past a digit already lit, its segments may predate the transfer
        while (digit_drive === (DRIVE_ONE << idx)) begin
            @(negedge clk);
            n++;
            if (n > 1100) begin
                n_mismatch++;
                wrap_up();
            end
        end
        while (digit_drive !== (DRIVE_ONE << idx)) begin
            @(negedge clk);
            n++;
            if (n > 1100) begin
                n_mismatch++;
                wrap_up();
            end
        end
        check("segments", 16'(segments), 16'(exp));
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        int n;
        reset_n = 1'b0;
        polarity_in = 1'b0;
        start_conversion = 1'b1;
        duty = 3'h0;
        rows[0] = '{3'h0, 1'b1, 1'b0, SEG_BLANK, SEG_0, SEG_0, SEG_0};
        rows[1] = '{3'h1, 1'b0, 1'b0, SEG_BLANK, SEG_5, SEG_0, SEG_0};
        rows[2] = '{3'h2, 1'b1, 1'b0, SEG_1, SEG_0, SEG_0, SEG_0};
        rows[3] = '{3'h3, 1'b0, 1'b0, SEG_1, SEG_5, SEG_0, SEG_0};
        rows[4] = '{3'h4, 1'b1, 1'b1, SEG_PLUS, SEG_LETTER_O, SEG_LETTER_F, SEG_LETTER_L};
        rows[5] = '{3'h4, 1'b0, 1'b1, SEG_MINUS, SEG_LETTER_O, SEG_LETTER_F, SEG_LETTER_L};
        repeat (6) @(negedge clk);
        check("complete in reset", 16'(conversion_complete), 16'h0000);
        reset_n = 1'b1;
        foreach (rows[i]) begin
            duty = rows[i].duty;
            polarity_in = rows[i].pol;
            wait_rise(n);
            wait_rise(n);
            check("refresh period", 16'(n), 16'(CYC));
            check("overrange", 16'(overrange), 16'(rows[i].over));
            check("sign", 16'(sign), 16'(rows[i].pol));
            check_digit(3, rows[i].s3);
            check_digit(2, rows[i].s2);
            check_digit(1, rows[i].s1);
            check_digit(0, rows[i].s0);
            $display("row %0d done", i);
        end
        start_conversion = 1'b0;
        duty = 3'h1;
        n = 0;
        repeat (9000) begin
            @(negedge clk);
            if (conversion_complete !== 1'b0) n++;
        end
        check("idle transfers", 16'(n), 16'h0000);
        check("held result", 16'(overrange), 16'h0001);
        $display("idle test done");
        repeat (2) begin
            start_conversion = 1'b1;
            repeat (4) @(negedge clk);
            start_conversion = 1'b0;
            wait_rise(n);
            check("start to complete", 16'(n >= 252 && n <= 4400), 16'h0001);
        end
        check("new result", 16'(overrange), 16'h0000);
        check_digit(2, SEG_5);
        $display("handshake done");
        reset_n = 1'b0;
        start_conversion = 1'b1;
        repeat (2) @(negedge clk);
        check("complete in mid reset", 16'(conversion_complete), 16'h0000);
        check("drive in mid reset", 16'(digit_drive), 16'h0000);
        check("segments in mid reset", 16'(segments), 16'h0000);
        reset_n = 1'b1;
        wait_rise(n);
        check("first refresh after reset", 16'(n), 16'(CYC));
        check("overrange after reset", 16'(overrange), 16'h0000);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule
bind dvm_core dvm_core_properties #(.CYCLE_CLOCKS(CYCLE_CLOCKS)) props (.clk(clk),
    .reset_n(reset_n), .ce(ce), .comparator_in(comparator_in), .polarity_in(polarity_in),
    .start_conversion(start_conversion), .reference_switch(reference_switch),
    .clock_out(clock_out), .segments(segments), .digit_drive(digit_drive),
    .overrange(overrange), .sign(sign), .conversion_complete(conversion_complete));

/* verilog/digit_store.sv */
// Purpose: display latch holding the shown digits, one digit read per clock
// Assumes: whole latch written at once, read data registered
// Notes: clock enable low freezes all contents
`timescale 1ns/1ns
module digit_store #(
    parameter int DIGITS = 4,
    parameter int WIDTH = 4,
    parameter int ADDR_W = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic write_en,
    input wire logic [DIGITS*WIDTH-1:0] write_data,
    input wire logic [ADDR_W-1:0] read_addr,
    output logic [WIDTH-1:0] read_data
);
    typedef struct packed {
        logic [DIGITS-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } store_s;

    store_s st;
    store_s next_st;

    always_comb begin
        next_st = st;
        next_st.rd = st.mem[read_addr];
        if (write_en) begin
            next_st.mem = write_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign read_data = st.rd;
endmodule

/* verilog/dvm_core.sv */
// Purpose: counter, timing and multiplexed display side of a pulse-modulation voltmeter
// Assumes: comparator, polarity and start inputs arrive as unsynchronised pins
// Notes: conversion runs continuously; start only governs the display transfer
//
// What this block does
// - each clock edge samples comparator into modulator
// - count clocks only while modulator is high
// - gated counter accumulates during timed window
// - window lasts 2000 clock periods
// - new digit every 256 clocks, blanked 1/32
// - overrange output high, display sign and overflow
// - blank most significant digit when zero
// - polarity sensed and driven on sign output
// - digit scan taken from conversion timing counter
// - provide square-wave clock output
// - start held high refreshes every cycle
// - conversion complete high 64 clocks after transfer
// - start edge drops complete, transfer raises it
// - conversion never stops for handshake pins
`timescale 1ns/1ns
module dvm_core
    import dvm_pkg::*;
#(
    parameter logic [dvm_pkg::CYCLE_W-1:0] CYCLE_CLOCKS = dvm_pkg::CYCLE_CLOCKS_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic comparator_in,
    input wire logic polarity_in,
    input wire logic start_conversion,
    output logic reference_switch,
    output logic clock_out,
    output logic [dvm_pkg::SEG_W-1:0] segments,
    output logic [dvm_pkg::DIGITS-1:0] digit_drive,
    output logic overrange,
    output logic sign,
    output logic conversion_complete
);
    import dvm_pkg::*;

    typedef struct packed {
        logic cmp_meta;
        logic cmp_sync;
        logic modulate;
        logic pol_meta;
        logic pol_sync;
        logic start_meta;
        logic start_sync;
        logic start_prev;
        logic pending;
        logic armed;
        logic [CYCLE_W-1:0] cycle;
        logic [DIGITS-1:0][BCD_W-1:0] acc;
        logic [DIGITS-1:0][BCD_W-1:0] result;
        logic result_positive;
        logic over;
        logic positive;
        logic done;
        logic [DONE_W-1:0] done_cnt;
        logic clk_div;
        logic [DIGIT_W-1:0] idx1;
        logic lit1;
        logic [SEG_W-1:0] seg;
        logic [DIGITS-1:0] drive;
    } core_s;

    core_s st;
    core_s next_st;

    logic window;
    logic [DIGITS:0] carry;
    logic [DIGITS-1:0][BCD_W-1:0] acc_inc;
    logic [BCD_W-1:0] shown;
    logic transfer;
    logic cycle_end;
    logic slot_end;
    logic start_edge;

    function automatic logic [SEG_W-1:0] seg_of(input logic [BCD_W-1:0] d);
        logic [SEG_W-1:0] p;
        p = SEG_BLANK;
        unique case (d)
            4'h0: p = SEG_0;
            4'h1: p = SEG_1;
            4'h2: p = SEG_2;
            4'h3: p = SEG_3;
            4'h4: p = SEG_4;
            4'h5: p = SEG_5;
            4'h6: p = SEG_6;
            4'h7: p = SEG_7;
            4'h8: p = SEG_8;
            4'h9: p = SEG_9;
            default: p = SEG_BLANK;
        endcase
        return p;
    endfunction

    assign window = st.cycle < WINDOW_CLOCKS;
    assign carry[0] = window & st.modulate;

    // decade counter, one carry stage per digit
    generate
        for (genvar i = 0; i < DIGITS; i++) begin : g_decade
            assign carry[i+1] = carry[i] & (st.acc[i] == BCD_NINE);
            assign acc_inc[i] = !carry[i] ? st.acc[i] :
                ((st.acc[i] == BCD_NINE) ? BCD_ZERO : st.acc[i] + BCD_ONE);
        end
    endgenerate

    assign cycle_end = st.cycle == CYCLE_CLOCKS - CYCLE_STEP;
    assign slot_end = st.cycle[SLOT_BITS-1:0] == SLOT_LAST;
    assign start_edge = st.start_sync & ~st.start_prev;
    // transfer only once armed at a slot end; a start edge while still armed from a held start can transfer under 256 clocks later
    assign transfer = cycle_end & st.armed;

    digit_store #(
        .DIGITS(DIGITS),
        .WIDTH(BCD_W),
        .ADDR_W(DIGIT_W)
    ) u_store (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .write_en(transfer),
        .write_data(st.result),
        .read_addr(st.cycle[SLOT_BITS+DIGIT_W-1:SLOT_BITS]),
        .read_data(shown)
    );

    always_comb begin
        next_st = st;

        next_st.cmp_meta = comparator_in;
        next_st.cmp_sync = st.cmp_meta;
        next_st.modulate = st.cmp_sync;
        next_st.pol_meta = polarity_in;
        next_st.pol_sync = st.pol_meta;
        next_st.start_meta = start_conversion;
        next_st.start_sync = st.start_meta;
        next_st.start_prev = st.start_sync;

        next_st.clk_div = ~st.clk_div;

        // free-running cycle counter, untouched by handshake
        if (cycle_end) begin
            next_st.cycle = '0;
        end else begin
            next_st.cycle = st.cycle + CYCLE_STEP;
        end

        if (st.cycle == WINDOW_CLOCKS) begin
            next_st.result = st.acc;
            next_st.result_positive = st.pol_sync;
            next_st.acc = '0;
        end else begin
            next_st.acc = acc_inc;
        end

        // pending start must survive a full slot before it may transfer
        if (slot_end) begin
            next_st.armed = st.pending | st.start_sync;
        end

        if (transfer) begin
            next_st.over = st.result[DIGITS-1] >= MSD_OVER;
            next_st.positive = st.result_positive;
            next_st.done = 1'b1;
            next_st.done_cnt = DONE_LAST;
            next_st.pending = 1'b0;
            next_st.armed = 1'b0;
        end else if (st.done) begin
            if (st.done_cnt == DONE_ZERO) begin
                next_st.done = 1'b0;
            end else begin
                next_st.done_cnt = st.done_cnt - DONE_STEP;
            end
        end

        // a start edge wins over a transfer in the same clock
        if (start_edge) begin
            next_st.pending = 1'b1;
            next_st.done = 1'b0;
        end

        // stage one: digit index and blank flag beside the store read
        next_st.idx1 = st.cycle[SLOT_BITS+DIGIT_W-1:SLOT_BITS];
        // lit flag, so the all-zero reset state shows no digit
        next_st.lit1 = st.cycle[SLOT_BITS-1:0] >= BLANK_CLOCKS;

        // stage two: segment pattern and digit drive
        if (!st.lit1) begin
            next_st.seg = SEG_BLANK;
            next_st.drive = DRIVE_NONE;
        end else begin
            next_st.drive = DRIVE_ONE << st.idx1;
            if (st.over) begin
                unique case (st.idx1)
                    DIGIT_MSD: next_st.seg = st.positive ? SEG_PLUS : SEG_MINUS;
                    DIGIT_HI: next_st.seg = SEG_LETTER_O;
                    DIGIT_MID: next_st.seg = SEG_LETTER_F;
                    DIGIT_LSD: next_st.seg = SEG_LETTER_L;
                endcase
            end else if (st.idx1 == DIGIT_MSD && shown == BCD_ZERO) begin
                next_st.seg = SEG_BLANK;
            end else begin
                next_st.seg = seg_of(shown);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign reference_switch = st.modulate;
    assign clock_out = st.clk_div;
    assign segments = st.seg;
    assign digit_drive = st.drive;
    assign overrange = st.over;
    assign sign = st.positive;
    assign conversion_complete = st.done;
endmodule

/* verilog/dvm_pkg.sv */
// Purpose: shared constants for the pulse-modulation voltmeter counter and display
// Assumes: one clock, all counts in input clock periods
// Notes: segment bits are ordered {g,f,e,d,c,b,a}, high lights a segment
package dvm_pkg;

    localparam int CYCLE_W = 16;
    localparam int SLOT_BITS = 8;
    localparam int DIGITS = 4;
    localparam int DIGIT_W = 2;
    localparam int BCD_W = 4;
    localparam int SEG_W = 7;
    localparam int DONE_W = 6;

    // conversion cycle length in clock periods
    localparam logic [CYCLE_W-1:0] CYCLE_CLOCKS_DEF = 16'hFC00;
    // measurement window, 2000 clock periods
    localparam logic [CYCLE_W-1:0] WINDOW_CLOCKS = 16'h07D0;
    localparam logic [CYCLE_W-1:0] CYCLE_STEP = 16'h0001;

    // digit slot of 256 clocks, blanked for the first 256/32 of it
    localparam logic [SLOT_BITS-1:0] SLOT_LAST = 8'hFF;
    localparam logic [SLOT_BITS-1:0] SLOT_CLOCKS_M1 = 8'hFF;
    localparam int BLANK_DIV = 32;
    localparam logic [SLOT_BITS-1:0] BLANK_CLOCKS = 8'h08;

    // conversion-complete high time, 64 clocks, held as last count
    localparam logic [DONE_W-1:0] DONE_LAST = 6'h3F;
    localparam logic [DONE_W-1:0] DONE_STEP = 6'h01;
    localparam logic [DONE_W-1:0] DONE_ZERO = 6'h00;

    localparam logic [BCD_W-1:0] BCD_ZERO = 4'h0;
    localparam logic [BCD_W-1:0] BCD_ONE = 4'h1;
    localparam logic [BCD_W-1:0] BCD_NINE = 4'h9;
    // most significant digit value that marks overrange
    localparam logic [BCD_W-1:0] MSD_OVER = 4'h2;

    localparam logic [DIGIT_W-1:0] DIGIT_LSD = 2'h0;
    localparam logic [DIGIT_W-1:0] DIGIT_MID = 2'h1;
    localparam logic [DIGIT_W-1:0] DIGIT_HI = 2'h2;
    localparam logic [DIGIT_W-1:0] DIGIT_MSD = 2'h3;

    localparam logic [SEG_W-1:0] SEG_BLANK = 7'h00;
    localparam logic [SEG_W-1:0] SEG_0 = 7'h3F;
    localparam logic [SEG_W-1:0] SEG_1 = 7'h06;
    localparam logic [SEG_W-1:0] SEG_2 = 7'h5B;
    localparam logic [SEG_W-1:0] SEG_3 = 7'h4F;
    localparam logic [SEG_W-1:0] SEG_4 = 7'h66;
    localparam logic [SEG_W-1:0] SEG_5 = 7'h6D;
    localparam logic [SEG_W-1:0] SEG_6 = 7'h7D;
    localparam logic [SEG_W-1:0] SEG_7 = 7'h07;
    localparam logic [SEG_W-1:0] SEG_8 = 7'h7F;
    localparam logic [SEG_W-1:0] SEG_9 = 7'h6F;
    localparam logic [SEG_W-1:0] SEG_LETTER_O = 7'h3F;
    localparam logic [SEG_W-1:0] SEG_LETTER_F = 7'h71;
    localparam logic [SEG_W-1:0] SEG_LETTER_L = 7'h38;
    localparam logic [SEG_W-1:0] SEG_MINUS = 7'h40;
    localparam logic [SEG_W-1:0] SEG_PLUS = 7'h46;

    localparam logic [DIGITS-1:0] DRIVE_NONE = 4'h0;
    localparam logic [DIGITS-1:0] DRIVE_ONE = 4'h1;

endpackage
